// ### rtl/ssm_pkg.sv
// Constants shared by the standstill and speed safety monitor
package ssm_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TICK_PERIOD_NS = 1_000_000;
  localparam int unsigned TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned REQ_LATENCY_NS = 2_000_000;
  localparam int unsigned REQ_LAT_CYCLES_DEF = (REQ_LATENCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned LONG_IDLE_DAYS = 10;
  localparam int unsigned MS_PER_DAY = 86_400_000;
  localparam int unsigned LONG_IDLE_TICKS_DEF = LONG_IDLE_DAYS * MS_PER_DAY;
  localparam int unsigned NUM_SPEED = 4;
  localparam int unsigned POS_W = 32;
  localparam int unsigned SPD_W = 16;
  localparam int unsigned TIME_W = 16;
  localparam int unsigned CNT_W = 32;
  localparam int unsigned SYNC_W = 2 + 2 * NUM_SPEED;
  localparam logic SYNC_RESET = 1'b0;
  typedef enum logic [3:0] {
    SSM_ST_IDLE = 4'h1,
    SSM_ST_WAIT = 4'h2,
    SSM_ST_DELAY = 4'h4,
    SSM_ST_MON = 4'h8
  } ssm_state_t;
endpackage

// ### rtl/ssm_monitor.sv
// Standstill monitor and four speed-range monitors of a servo drive safety module
`timescale 1ns/1ns
module ssm_monitor #(
  parameter int unsigned TICK_CYCLES = ssm_pkg::TICK_CYCLES_DEF,
  parameter int unsigned REQ_LAT_CYCLES = ssm_pkg::REQ_LAT_CYCLES_DEF,
  parameter int unsigned LONG_IDLE_TICKS = ssm_pkg::LONG_IDLE_TICKS_DEF
) (
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic standstill_request_in,
  input wire logic standstill_cancel_in,
  input wire logic stop_two_standstill_request_in,
  input wire logic [ssm_pkg::TIME_W-1:0] standstill_monitor_start_delay_in,
  input wire logic [ssm_pkg::POS_W-1:0] standstill_tolerance_window_in,
  input wire logic standstill_quick_stop_enable_in,
  input wire logic standstill_auto_restart_in,
  input wire logic signed [ssm_pkg::POS_W-1:0] position_in,
  input wire logic position_invalid_in,
  input wire logic idle_motion_in,
  input wire logic signed [ssm_pkg::SPD_W-1:0] speed_in,
  input wire logic speed_invalid_in,
  input wire logic [ssm_pkg::NUM_SPEED-1:0] speed_monitor_request_in,
  input wire logic [ssm_pkg::NUM_SPEED-1:0] speed_monitor_cancel_in,
  input wire logic [ssm_pkg::NUM_SPEED-1:0] speed_monitor_activate_in,
  input wire logic [ssm_pkg::NUM_SPEED-1:0] speed_monitor_auto_restart_in,
  input wire logic [ssm_pkg::NUM_SPEED*ssm_pkg::SPD_W-1:0] speed_min_final_in,
  input wire logic [ssm_pkg::NUM_SPEED*ssm_pkg::SPD_W-1:0] speed_max_final_in,
  input wire logic [ssm_pkg::NUM_SPEED*ssm_pkg::SPD_W-1:0] speed_ramp_step_in,
  input wire logic [ssm_pkg::NUM_SPEED*ssm_pkg::SPD_W-1:0] speed_start_margin_in,
  output logic standstill_requested_out,
  output logic standstill_safe_state_out,
  output logic standstill_error_out,
  output logic long_idle_error_out,
  output logic quick_stop_out,
  output logic [ssm_pkg::NUM_SPEED-1:0] speed_monitor_requested_out,
  output logic [ssm_pkg::NUM_SPEED-1:0] speed_monitor_safe_state_out,
  output logic [ssm_pkg::NUM_SPEED-1:0] speed_monitor_error_out,
  output logic [ssm_pkg::NUM_SPEED*ssm_pkg::SPD_W-1:0] speed_limit_min_out,
  output logic [ssm_pkg::NUM_SPEED*ssm_pkg::SPD_W-1:0] speed_limit_max_out
);
  import ssm_pkg::*;

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!nrst_in);

  // Pin synchronisers: value moves only when stages two and three agree
  logic [SYNC_W-1:0] raw_in;
  logic [SYNC_W-1:0] s1_q;
  logic [SYNC_W-1:0] s2_q;
  logic [SYNC_W-1:0] s3_q;
  logic [SYNC_W-1:0] filt_q;
  assign raw_in = {speed_monitor_cancel_in, speed_monitor_request_in, standstill_cancel_in, standstill_request_in};

  genvar b;
  generate
    for (b = 0; b < SYNC_W; b++)
    begin : g_sync
      always_ff @(posedge ref_clk_in or negedge nrst_in)
      begin
        if (!nrst_in)
        begin
          s1_q[b] <= SYNC_RESET;
          s2_q[b] <= SYNC_RESET;
          s3_q[b] <= SYNC_RESET;
          filt_q[b] <= SYNC_RESET;
        end
        else
        begin
          s1_q[b] <= raw_in[b];
          s2_q[b] <= s1_q[b];
          s3_q[b] <= s2_q[b];
          if (s2_q[b] == s3_q[b])
            filt_q[b] <= s3_q[b];
        end
      end
    end
  endgenerate

  logic ss_req_f;
  logic ss_cancel_f;
  logic [NUM_SPEED-1:0] spd_req_f;
  logic [NUM_SPEED-1:0] spd_cancel_f;
  assign ss_req_f = filt_q[0];
  assign ss_cancel_f = filt_q[1];
  assign spd_req_f = filt_q[2 +: NUM_SPEED];
  assign spd_cancel_f = filt_q[2 + NUM_SPEED +: NUM_SPEED];

  // Millisecond tick shared by every timer except the request-latency counters, which count clock cycles
  logic [CNT_W-1:0] tick_cnt_q;
  logic tick_q;
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end
    else if (tick_cnt_q == CNT_W'(TICK_CYCLES - 1))
    begin
      tick_cnt_q <= '0;
      tick_q <= 1'b1;
    end
    else
    begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  // Standstill request and cancel; a pending request blocks any cancel
  logic ss_req_any;
  logic ss_active_q;
  assign ss_req_any = ss_req_f | stop_two_standstill_request_in;
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      ss_active_q <= 1'b0;
    else if (ss_req_any)
      ss_active_q <= 1'b1;
    else if (ss_cancel_f || standstill_auto_restart_in)
      ss_active_q <= 1'b0;
  end

  // Standstill sequence: latency wait, start delay, then monitoring
  ssm_state_t ss_state_q;
  logic [CNT_W-1:0] ss_lat_q;
  logic [TIME_W-1:0] ss_dly_q;
  logic signed [POS_W-1:0] ss_ref_q;
  logic ss_delay_done;
  assign ss_delay_done = tick_q && (ss_dly_q >= standstill_monitor_start_delay_in);
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      ss_state_q <= SSM_ST_IDLE;
      ss_lat_q <= '0;
      ss_dly_q <= '0;
      ss_ref_q <= '0;
    end
    else if (!ss_active_q)
    begin
      ss_state_q <= SSM_ST_IDLE;
      ss_lat_q <= '0;
      ss_dly_q <= '0;
    end
    else
    begin
      case (ss_state_q)
        SSM_ST_IDLE:
          ss_state_q <= SSM_ST_WAIT;
        SSM_ST_WAIT:
        begin
          ss_lat_q <= ss_lat_q + 1'b1;
          if (ss_lat_q == CNT_W'(REQ_LAT_CYCLES - 1))
            ss_state_q <= SSM_ST_DELAY;
        end
        SSM_ST_DELAY:
          if (ss_delay_done)
          begin
            ss_ref_q <= position_in;
            ss_state_q <= SSM_ST_MON;
          end
          else if (tick_q)
            ss_dly_q <= ss_dly_q + 1'b1;
        SSM_ST_MON:
          ss_state_q <= SSM_ST_MON;
        default:
          ss_state_q <= SSM_ST_IDLE;
      endcase
    end
  end

  // Drift check runs on each tick, so detection lags by at most one millisecond
  logic signed [POS_W:0] ss_diff;
  logic [POS_W:0] ss_abs;
  logic ss_over_tol;
  logic ss_viol;
  assign ss_diff = {position_in[POS_W-1], position_in} - {ss_ref_q[POS_W-1], ss_ref_q};
  assign ss_abs = ss_diff[POS_W] ? (POS_W+1)'(-ss_diff) : ss_diff;
  assign ss_over_tol = ss_abs > {1'b0, standstill_tolerance_window_in};
  assign ss_viol = (ss_active_q && position_invalid_in)
    || ((ss_state_q == SSM_ST_MON) && (idle_motion_in || (tick_q && ss_over_tol)));

  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      standstill_error_out <= 1'b0;
      standstill_requested_out <= 1'b0;
      standstill_safe_state_out <= 1'b0;
      quick_stop_out <= 1'b0;
    end
    else
    begin
      if (!ss_active_q)
        standstill_error_out <= 1'b0;
      else if (ss_viol)
        standstill_error_out <= 1'b1;
      standstill_requested_out <= ss_active_q && (ss_state_q == SSM_ST_DELAY || ss_state_q == SSM_ST_MON);
      standstill_safe_state_out <= ss_active_q && (ss_state_q == SSM_ST_MON)
        && !standstill_error_out && !ss_viol;
      quick_stop_out <= ss_active_q && standstill_quick_stop_enable_in;
    end
  end

  // Encoder signals may be static at rest, so endless standstill is bounded
  logic [CNT_W-1:0] ss_idle_q;
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      ss_idle_q <= '0;
      long_idle_error_out <= 1'b0;
    end
    else if (!ss_active_q)
    begin
      ss_idle_q <= '0;
      long_idle_error_out <= 1'b0;
    end
    else if (tick_q)
    begin
      if (ss_idle_q >= CNT_W'(LONG_IDLE_TICKS))
        long_idle_error_out <= 1'b1;
      else
        ss_idle_q <= ss_idle_q + 1'b1;
    end
  end

  a_quick_stop_follow: assert property (ss_active_q && standstill_quick_stop_enable_in |=> quick_stop_out)
    else $error("quick stop not asserted");
  a_invalid_sets_error: assert property (ss_active_q && position_invalid_in |=> ##1 standstill_error_out)
    else $error("invalid position not flagged");
  a_ref_latched: assert property (ss_active_q && ss_state_q == SSM_ST_DELAY && ss_delay_done
    |=> ss_ref_q == $past(position_in) && ss_state_q == SSM_ST_MON)
    else $error("reference position not latched");
  a_window_exit: assert property (ss_active_q && ss_state_q == SSM_ST_MON && tick_q && ss_over_tol
    |=> ##1 standstill_error_out)
    else $error("tolerance overrun missed");
  a_idle_motion_err: assert property (ss_active_q && ss_state_q == SSM_ST_MON && idle_motion_in
    |-> ##[1:2] standstill_error_out)
    else $error("idle motion not flagged");
  a_safe_clean: assert property (standstill_safe_state_out |-> !standstill_error_out && standstill_requested_out)
    else $error("safe state with error");
  a_req_latency: assert property ($rose(standstill_requested_out) |-> $past(ss_lat_q, 2) == CNT_W'(REQ_LAT_CYCLES - 1))
    else $error("requested latency wrong");
  a_cancel_blocked: assert property (ss_req_any && ss_active_q |=> ss_active_q)
    else $error("cancel overrode request");
  a_auto_restart: assert property (ss_active_q && !ss_req_any && standstill_auto_restart_in |=> !ss_active_q)
    else $error("auto restart did not cancel");

  // Ramp one limit toward its final value by one step, never overshooting
  function automatic logic signed [SPD_W:0] ssm_ramp(input logic signed [SPD_W:0] cur,
    input logic signed [SPD_W:0] fin, input logic signed [SPD_W:0] step);
    logic signed [SPD_W+1:0] nxt;
    nxt = '0;
    if (cur > fin)
    begin
      nxt = {cur[SPD_W], cur} - {step[SPD_W], step};
      // Signed compare, else a ramp crossing zero clamps early
      ssm_ramp = (nxt < $signed({fin[SPD_W], fin})) ? fin : nxt[SPD_W:0];
    end
    else
    begin
      nxt = {cur[SPD_W], cur} + {step[SPD_W], step};
      ssm_ramp = (nxt > $signed({fin[SPD_W], fin})) ? fin : nxt[SPD_W:0];
    end
  endfunction

  genvar i;
  generate
    for (i = 0; i < NUM_SPEED; i++)
    begin : g_speed
      logic active_q;
      logic [CNT_W-1:0] lat_q;
      logic signed [SPD_W:0] lim_min_q;
      logic signed [SPD_W:0] lim_max_q;
      logic signed [SPD_W:0] fin_min;
      logic signed [SPD_W:0] fin_max;
      logic signed [SPD_W:0] step;
      logic signed [SPD_W:0] margin;
      logic signed [SPD_W:0] spd;
      logic ramp_done;
      logic out_of_range;
      assign fin_min = {speed_min_final_in[i*SPD_W+SPD_W-1], speed_min_final_in[i*SPD_W +: SPD_W]};
      assign fin_max = {speed_max_final_in[i*SPD_W+SPD_W-1], speed_max_final_in[i*SPD_W +: SPD_W]};
      assign step = {1'b0, speed_ramp_step_in[i*SPD_W +: SPD_W]};
      assign margin = {1'b0, speed_start_margin_in[i*SPD_W +: SPD_W]};
      assign spd = {speed_in[SPD_W-1], speed_in};
      assign ramp_done = (lim_min_q == fin_min) && (lim_max_q == fin_max);
      assign out_of_range = speed_invalid_in || spd > lim_max_q || spd < lim_min_q;

      always_ff @(posedge ref_clk_in or negedge nrst_in)
      begin
        if (!nrst_in)
          active_q <= 1'b0;
        else if (spd_req_f[i] && (speed_monitor_activate_in[i] || active_q))
          active_q <= 1'b1;
        else if (!spd_req_f[i] && (spd_cancel_f[i] || speed_monitor_auto_restart_in[i]))
          active_q <= 1'b0;
      end

      // Limits start around the current speed and taper into the final corridor
      always_ff @(posedge ref_clk_in or negedge nrst_in)
      begin
        if (!nrst_in)
        begin
          lat_q <= '0;
          lim_min_q <= '0;
          lim_max_q <= '0;
          speed_monitor_requested_out[i] <= 1'b0;
          speed_monitor_safe_state_out[i] <= 1'b0;
          speed_monitor_error_out[i] <= 1'b0;
        end
        else if (!active_q)
        begin
          lat_q <= '0;
          lim_min_q <= spd - margin;
          lim_max_q <= spd + margin;
          speed_monitor_requested_out[i] <= 1'b0;
          speed_monitor_safe_state_out[i] <= 1'b0;
          speed_monitor_error_out[i] <= 1'b0;
        end
        else if (lat_q != CNT_W'(REQ_LAT_CYCLES))
          lat_q <= lat_q + 1'b1;
        else
        begin
          speed_monitor_requested_out[i] <= 1'b1;
          if (tick_q)
          begin
            lim_min_q <= ssm_ramp(lim_min_q, fin_min, step);
            lim_max_q <= ssm_ramp(lim_max_q, fin_max, step);
          end
          if (out_of_range)
            speed_monitor_error_out[i] <= 1'b1;
          speed_monitor_safe_state_out[i] <= ramp_done && !out_of_range && !speed_monitor_error_out[i];
        end
      end

      assign speed_limit_min_out[i*SPD_W +: SPD_W] = lim_min_q[SPD_W-1:0];
      assign speed_limit_max_out[i*SPD_W +: SPD_W] = lim_max_q[SPD_W-1:0];

      a_spd_ignored: assert property (!active_q && !speed_monitor_activate_in[i] |=> !active_q)
        else $error("speed request accepted while inactive");
      a_spd_range_err: assert property (active_q && speed_monitor_requested_out[i] && out_of_range
        |=> speed_monitor_error_out[i])
        else $error("speed range violation missed");
    end
  endgenerate
endmodule

// ### verif/ssm_feedback_model.sv
// Encoder and basic-unit stand-in that feeds position and speed back to the monitor
`timescale 1ns/1ns
module ssm_feedback_model (
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic quick_stop_in,
  input wire logic [31:0] pos_jump_in,
  input wire logic jump_en_in,
  input wire logic wiggle_in,
  input wire logic pos_bad_in,
  input wire logic signed [15:0] spd_cmd_in,
  input wire logic spd_bad_in,
  output logic signed [31:0] position_out,
  output logic position_invalid_out,
  output logic idle_motion_out,
  output logic signed [15:0] speed_out,
  output logic speed_invalid_out
);
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      position_out <= 32'h0000_1000;
      position_invalid_out <= 1'b0;
      idle_motion_out <= 1'b0;
      speed_out <= 16'h0000;
      speed_invalid_out <= 1'b0;
    end
    else
    begin
      // A failed encoder reports garbage, so flip the value each cycle
      if (pos_bad_in)
        position_out <= ~position_out;
      else if (jump_en_in)
        position_out <= position_out + pos_jump_in;
      position_invalid_out <= pos_bad_in;
      idle_motion_out <= wiggle_in;
      // Braked drive reports zero speed
      speed_out <= quick_stop_in ? 16'h0000 : spd_cmd_in;
      speed_invalid_out <= spd_bad_in;
    end
  end
endmodule

// ### verif/tb_standstill_speed_safety_monitor.sv
// Self-checking bench for the standstill and speed safety monitor
`timescale 1ns/1ns
module tb_standstill_speed_safety_monitor;
  import ssm_pkg::*;
  typedef struct {logic [11:0] v; int lo; int hi;} ssm_note_t;
  logic ref_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic st_req = 1'b0, st_cancel = 1'b0, two_req = 1'b0, qs_en = 1'b0, st_auto = 1'b0;
  logic jump_en = 1'b0, wiggle = 1'b0, pos_bad = 1'b0, spd_bad = 1'b0;
  logic [15:0] st_delay = 16'h0002;
  logic [31:0] tol = 32'h0000_0005, jump = 32'h0000_0000;
  logic signed [15:0] spd_cmd = 16'h0000, s_val;
  logic [3:0] sp_req = 4'h0, sp_cancel = 4'h0, sp_act = 4'h0, sp_auto = 4'h0;
  logic [63:0] min_f = 64'h0, max_f = 64'h0, step = 64'h0, margin = 64'h0;
  wire logic signed [31:0] pos;
  wire logic signed [15:0] spd;
  wire logic pos_inv, idle_mv, spd_inv, st_rq_o, st_safe_o, st_err_o, li_err_o, qs_o;
  wire logic [3:0] sp_rq_o, sp_safe_o, sp_err_o;
  wire logic [63:0] lim_min_o, lim_max_o;
  int err_total = 0, num_checks = 0, cyc = 0;
  ssm_note_t st_q[$], sp_q[$];
  logic [4:0] st_prev = 5'h00;
  logic [11:0] sp_prev = 12'h000;

  ssm_feedback_model fb_u (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .quick_stop_in(qs_o),
    .pos_jump_in(jump), .jump_en_in(jump_en), .wiggle_in(wiggle), .pos_bad_in(pos_bad),
    .spd_cmd_in(spd_cmd), .spd_bad_in(spd_bad), .position_out(pos), .position_invalid_out(pos_inv),
    .idle_motion_out(idle_mv), .speed_out(spd), .speed_invalid_out(spd_inv));

  ssm_monitor #(.TICK_CYCLES(10), .REQ_LAT_CYCLES(20), .LONG_IDLE_TICKS(50)) dut_u (
    .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .standstill_request_in(st_req),
    .standstill_cancel_in(st_cancel), .stop_two_standstill_request_in(two_req),
    .standstill_monitor_start_delay_in(st_delay), .standstill_tolerance_window_in(tol),
    .standstill_quick_stop_enable_in(qs_en), .standstill_auto_restart_in(st_auto),
    .position_in(pos), .position_invalid_in(pos_inv), .idle_motion_in(idle_mv), .speed_in(spd),
    .speed_invalid_in(spd_inv), .speed_monitor_request_in(sp_req), .speed_monitor_cancel_in(sp_cancel),
    .speed_monitor_activate_in(sp_act), .speed_monitor_auto_restart_in(sp_auto),
    .speed_min_final_in(min_f), .speed_max_final_in(max_f), .speed_ramp_step_in(step),
    .speed_start_margin_in(margin), .standstill_requested_out(st_rq_o),
    .standstill_safe_state_out(st_safe_o), .standstill_error_out(st_err_o),
    .long_idle_error_out(li_err_o), .quick_stop_out(qs_o), .speed_monitor_requested_out(sp_rq_o),
    .speed_monitor_safe_state_out(sp_safe_o), .speed_monitor_error_out(sp_err_o),
    .speed_limit_min_out(lim_min_o), .speed_limit_max_out(lim_max_o));

  always #5 ref_clk_in = ~ref_clk_in;

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t %s exp %h got %h", $time, what, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Note the next expected output change and its cycle window
  task automatic note(input bit sp, input logic [11:0] v, input int lo, input int hi);
    if (sp)
      sp_q.push_back('{v, cyc + lo, cyc + hi});
    else
      st_q.push_back('{v, cyc + lo, cyc + hi});
  endtask

  task automatic take(input bit sp, input logic [11:0] v);
    ssm_note_t n;
    if ((sp ? sp_q.size() : st_q.size()) == 0)
    begin
      err_total++;
      $display("[FAIL] %0t unexpected output change %h", $time, v);
    end
    else
    begin
      n = sp ? sp_q.pop_front() : st_q.pop_front();
      chk("output vector", {52'h0, n.v}, {52'h0, v});
      chk("change timing", 64'h1, {63'h0, (cyc >= n.lo) && (cyc <= n.hi)});
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask

  task automatic do_jump(input logic [31:0] d);
    jump <= d;
    jump_en <= 1'b1;
    wait_cyc(1);
    jump_en <= 1'b0;
    wait_cyc(30);
  endtask

  always @(posedge ref_clk_in)
  begin
    cyc <= cyc + 1;
    if (nrst_in && {li_err_o, st_err_o, st_safe_o, st_rq_o, qs_o} !== st_prev)
      take(1'b0, {7'h00, li_err_o, st_err_o, st_safe_o, st_rq_o, qs_o});
    if (nrst_in && {sp_err_o, sp_safe_o, sp_rq_o} !== sp_prev)
      take(1'b1, {sp_err_o, sp_safe_o, sp_rq_o});
    st_prev <= {li_err_o, st_err_o, st_safe_o, st_rq_o, qs_o};
    sp_prev <= {sp_err_o, sp_safe_o, sp_rq_o};
  end

  initial
  begin
    wait_cyc(5000);
    err_total++;
    $display("[FAIL] %0t watchdog expired", $time);
    tally_and_finish();
  end

  initial
  begin
    void'($urandom(32'h9571));
    s_val = 16'($urandom_range(200)) - 16'h0064;
    wait_cyc(12);
    nrst_in <= 1'b1;
    tol <= 32'($urandom_range(8, 4));
    wait_cyc(3);
    qs_en <= 1'b1;
    st_auto <= 1'b1;
    st_req <= 1'b1;
    note(0, 12'h001, 4, 12);
    note(0, 12'h003, 26, 34);
    note(0, 12'h007, 44, 70);
    wait_cyc(90);
    wiggle <= 1'b1;
    note(0, 12'h00B, 1, 6);
    wait_cyc(10);
    st_req <= 1'b0;
    note(0, 12'h000, 3, 12);
    wait_cyc(30);
    wiggle <= 1'b0;
    $display("test standstill idle motion done");
    qs_en <= 1'b0;
    st_auto <= 1'b0;
    st_req <= 1'b1;
    note(0, 12'h002, 26, 34);
    note(0, 12'h006, 44, 70);
    wait_cyc(90);
    // Exactly at the tolerance edge must still pass
    do_jump(tol);
    note(0, 12'h00A, 1, 15);
    do_jump(32'h0000_0001);
    st_cancel <= 1'b1;
    wait_cyc(20);
    st_cancel <= 1'b0;
    st_req <= 1'b0;
    wait_cyc(20);
    st_cancel <= 1'b1;
    note(0, 12'h000, 3, 12);
    wait_cyc(20);
    st_cancel <= 1'b0;
    $display("test standstill tolerance done");
    two_req <= 1'b1;
    note(0, 12'h002, 20, 32);
    wait_cyc(40);
    pos_bad <= 1'b1;
    note(0, 12'h00A, 1, 6);
    note(0, 12'h01A, 440, 540);
    wait_cyc(560);
    pos_bad <= 1'b0;
    two_req <= 1'b0;
    st_cancel <= 1'b1;
    note(0, 12'h000, 3, 12);
    wait_cyc(20);
    st_cancel <= 1'b0;
    $display("test stop-two and long idle done");
    spd_cmd <= s_val;
    min_f <= {4{s_val - 16'h0028}};
    max_f <= {4{s_val + 16'h0028}};
    step <= {4{16'h000A}};
    margin <= {4{16'h000F}};
    sp_act <= 4'b0101;
    sp_auto <= 4'b0100;
    wait_cyc(5);
    sp_req <= 4'hF;
    note(1, 12'h005, 24, 34);
    note(1, 12'h055, 28, 90);
    wait_cyc(100);
    chk("min limit", {48'h0, s_val - 16'h0028}, {48'h0, lim_min_o[15:0]});
    chk("max limit", {48'h0, s_val + 16'h0028}, {48'h0, lim_max_o[47:32]});
    spd_cmd <= s_val + 16'h0029;
    note(1, 12'h505, 1, 6);
    sp_cancel <= 4'b0001;
    wait_cyc(20);
    sp_cancel <= 4'b0000;
    sp_req <= 4'b1010;
    note(1, 12'h101, 3, 12);
    wait_cyc(20);
    sp_cancel <= 4'b0001;
    note(1, 12'h000, 3, 12);
    wait_cyc(20);
    // Invalid speed feedback must count as leaving the range
    sp_cancel <= 4'b0000;
    spd_cmd <= s_val;
    sp_req <= 4'b0001;
    note(1, 12'h001, 24, 34);
    note(1, 12'h011, 28, 90);
    wait_cyc(100);
    spd_bad <= 1'b1;
    note(1, 12'h101, 1, 6);
    wait_cyc(20);
    spd_bad <= 1'b0;
    sp_req <= 4'b0000;
    sp_cancel <= 4'b0001;
    note(1, 12'h000, 3, 12);
    wait_cyc(20);
    $display("test speed monitors done");
    chk("pending notes", 64'h0, 64'(st_q.size() + sp_q.size()));
    tally_and_finish();
  end
endmodule
